/* File: common/fault_readout_defines.vh */
// constants shared by the status readout design files
`ifndef FAULT_READOUT_DEFINES_VH
`define FAULT_READOUT_DEFINES_VH

// word geometry
`define WORD_W          16
`define ADDR_MSB        15
`define ADDR_LSB        12
`define FAILSAFE_BIT    11
`define NUM_CH          5
`define CH_FLAG_W       7
`define DEV_FLAG_W      7

// read addresses of the status words
`define ADDR_INIT1      4'h0
`define ADDR_QUICK      4'h1
`define ADDR_CH1        4'h2
`define ADDR_CH5        4'h6
`define ADDR_DEVICE     4'h7
`define ADDR_LIVE_PINS  4'h8
`define ADDR_IDENTITY   4'h9

// fields of the first initialization word received on the serial input
`define SI_RSEL_MSB     3
`define SI_RSEL_LSB     0
`define SI_PERSIST_BIT  4

// channel latch layout {ots, otw, oc2, oc1, oc0, olon, oloff}
`define CH_OTS_BIT      6
`define CH_OTW_BIT      5
`define CH_OC_MSB       4
`define CH_OC_LSB       2
`define CH_OLON_BIT     1
`define CH_OLOFF_BIT    0
`define CH_OC_MASK      7'h1C

// device latch layout {tmf, ovf, uvf, serial_link_fail_flag, cpf, pwm_clock_fault, rcf}
`define DEV_TMF_BIT     6
`define DEV_OVF_BIT     5
`define DEV_UVF_BIT     4
`define DEV_SERIAL_LINK_FAIL_FLAG_BIT    3
`define DEV_CPF_BIT     2
`define DEV_PWM_CLOCK_FAULT_BIT    1
`define DEV_RCF_BIT     0

// frame length and misc values
`define FRAME_BITS      5'h10
`define BIT_CNT_W       5
`define ID_BLANK        8'h00
`define PIN_SYNC_W      14

`endif

/* File: hdl/pin_sync.v */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter           W       = 1,
  parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
  input  wire         ref_clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] stable_ff;

  // first stage feeds only the second stage
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_ff   <= RST_VAL;
      stable_ff <= RST_VAL;
    end else begin
      meta_ff   <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule // pin_sync

/* File: hdl/fault_latch.v */
// bank of sticky fault flags, set wins over a clear by reading
`timescale 1ns/100ps
module fault_latch #(
  parameter           W = 1
) (
  input  wire         ref_clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] replace_in,
  input  wire         clr_in,
  output wire [W-1:0] flags_out
);

  reg  [W-1:0] flags_ff;
  wire [W-1:0] nxt_flags;

  // replaced bits drop their old value so only the newest event shows
  assign nxt_flags = (flags_ff & ~replace_in & ~{W{clr_in}}) | set_in;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_ff <= {W{1'b0}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_out = flags_ff;

endmodule // fault_latch

/* File: hdl/switch_fault_status_readout.v */
// serial status readout of a five channel high side switch
//
// Overview of operation
// - host picks the returned word by a four-bit read address in init word one
// - persistence 0: programmed address serves one read, then quick status returns
// - persistence 1: programmed address serves every read until reprogrammed
// - every word carries its address in 15:12 and the failsafe bit in 11
// - read address 0 returns the quick status word, address field 0001
// - global flags in 10:8 of quick, channel, device words; clear with their faults
// - global device flag is OR of reset, uv, ov, pump, clock, test flags
// - global overload flag is OR of all overcurrent and shutdown flags
// - registers reset flag sets whenever the registers return to defaults
// - quick word bits 4:0 hold one OR summary flag per channel
// - channel words: ots 6, otw 5, overcurrent class 4:2, olon 1, oloff 0
// - a new overcurrent event replaces an unread overcurrent class
// - device word: test 4, ov 3, uv 2, link fail 1, live limp input 0
// - pin word is live: toggle OR in 9, inputs 8:5, comparators 4:0
// - comparator bits are live and undefined during undervoltage
// - identity word returns the part code in 7:0
// - identity field reads zero while undervoltage is flagged
// - a latched channel fault stays set until that channel word is read
`timescale 1ns/100ps
`include "fault_readout_defines.vh"
module switch_fault_status_readout #(
  parameter [7:0]  PART_CODE = 8'h5A   // arbitrary value
) (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire        spi_sclk_in,
  input  wire        spi_cs_n_in,
  input  wire        spi_mosi_in,
  output reg         spi_miso_out,
  output reg         spi_miso_oe_out,
  output reg  [3:0]  read_address_select_out,
  output reg         readback_persistence_out,
  input  wire        fail_mode_in,
  input  wire [4:0]  ots_evt_in,
  input  wire [4:0]  otw_evt_in,
  input  wire [4:0]  oc_evt_in,
  input  wire [14:0] oc_class_in,
  input  wire [4:0]  olon_evt_in,
  input  wire [4:0]  oloff_evt_in,
  input  wire        factory_test_evt_in,
  input  wire        overvoltage_evt_in,
  input  wire        undervoltage_evt_in,
  input  wire        serial_fail_evt_in,
  input  wire        charge_pump_evt_in,
  input  wire        pwm_clock_evt_in,
  input  wire        limp_home_pin_in,
  input  wire [3:0]  control_input_pin_in,
  input  wire [3:0]  toggle_pin_in,
  input  wire [4:0]  output_comparator_pin_in
);

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wire [2:0]                   link_sync;
  wire [`PIN_SYNC_W-1:0]       pin_sync_q;
  wire                         sclk_s;
  wire                         cs_n_s;
  wire                         mosi_s;
  wire                         limp_home_input_state;
  wire [3:0]                   control_input_state;
  wire [3:0]                   toggle_state;
  wire [4:0]                   output_comparator_state;
  reg                          sclk_d_ff;
  wire                         sclk_rise;
  wire                         sclk_fall;
  reg  [1:0]                   state_ff;
  reg  [`WORD_W-1:0]           tx_ff;
  reg  [`WORD_W-1:0]           rx_ff;
  reg  [`BIT_CNT_W-1:0]        bit_cnt_ff;
  reg                          rst_seen_ff;
  wire                         frame_start;
  wire [4:0]                   clr_ch;
  wire                         clr_dev;
  wire [`CH_FLAG_W*`NUM_CH-1:0] ch_flags;
  wire [`DEV_FLAG_W-1:0]       dev_set;
  wire [`DEV_FLAG_W-1:0]       dev_flags;
  wire [4:0]                   channel_summary_flag;
  wire                         any_ch_overload;
  wire                         any_ch_openload;
  wire                         global_device_flag;
  wire                         global_overload_flag;
  wire                         global_openload_flag;
  wire [2:0]                   global_flags;
  wire                         failsafe_indicator;
  reg  [`WORD_W-1:0]           read_word;
  reg  [3:0]                   rd_ch_idx;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; chip select idles high so it resets high

  pin_sync #(
    .W       (3),
    .RST_VAL (3'b010)
  ) u_link_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({spi_sclk_in, spi_cs_n_in, spi_mosi_in}),
    .sync_out   (link_sync)
  );

  assign sclk_s = link_sync[2];
  assign cs_n_s = link_sync[1];
  assign mosi_s = link_sync[0];

  // live pins, reported unlatched after the sync delay
  pin_sync #(
    .W       (`PIN_SYNC_W),
    .RST_VAL ({`PIN_SYNC_W{1'b0}})
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({limp_home_pin_in, control_input_pin_in, toggle_pin_in,
                  output_comparator_pin_in}),
    .sync_out   (pin_sync_q)
  );

  assign limp_home_input_state   = pin_sync_q[13];
  assign control_input_state     = pin_sync_q[12:9];
  assign toggle_state            = pin_sync_q[8:5];
  assign output_comparator_state = pin_sync_q[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // clear on read: taken in the capture cycle so an event in that same
  // cycle lands in the latch after the clear and is not lost

  assign frame_start = state_ff[0] & ~cs_n_s;

  always @* begin
    rd_ch_idx = read_address_select_out - `ADDR_CH1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_ch
      assign clr_ch[gi] = frame_start & (rd_ch_idx == gi);

      // oc class bits are replaced, the rest stay sticky
      fault_latch #(
        .W (`CH_FLAG_W)
      ) u_ch_latch (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     ({ots_evt_in[gi], otw_evt_in[gi],
                      oc_class_in[3*gi+2:3*gi] & {3{oc_evt_in[gi]}},
                      olon_evt_in[gi], oloff_evt_in[gi]}),
        .replace_in (`CH_OC_MASK & {`CH_FLAG_W{oc_evt_in[gi]}}),
        .clr_in     (clr_ch[gi]),
        .flags_out  (ch_flags[`CH_FLAG_W*gi+`CH_FLAG_W-1:`CH_FLAG_W*gi])
      );

      // per channel summary for the quick word
      assign channel_summary_flag[gi] =
        |ch_flags[`CH_FLAG_W*gi+`CH_FLAG_W-1:`CH_FLAG_W*gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // device flags, cleared by reading the device word

  assign clr_dev = frame_start & (read_address_select_out == `ADDR_DEVICE);

  // the reset flag is raised in the first cycle after any reset
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
    end
  end

  assign dev_set = {factory_test_evt_in, overvoltage_evt_in, undervoltage_evt_in,
                    serial_fail_evt_in, charge_pump_evt_in, pwm_clock_evt_in,
                    ~rst_seen_ff};

  fault_latch #(
    .W (`DEV_FLAG_W)
  ) u_dev_latch (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .set_in     (dev_set),
    .replace_in ({`DEV_FLAG_W{1'b0}}),
    .clr_in     (clr_dev),
    .flags_out  (dev_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // global flags follow the latches, so they fall only when all are read

  generate
    for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_or
      wire ovl_bit;
      wire ol_bit;
      assign ovl_bit = ch_flags[`CH_FLAG_W*gi+`CH_OTS_BIT] |
                       (|ch_flags[`CH_FLAG_W*gi+`CH_OC_MSB:`CH_FLAG_W*gi+`CH_OC_LSB]);
      assign ol_bit  = ch_flags[`CH_FLAG_W*gi+`CH_OLON_BIT] |
                       ch_flags[`CH_FLAG_W*gi+`CH_OLOFF_BIT];
    end
  endgenerate

  assign any_ch_overload = g_or[0].ovl_bit | g_or[1].ovl_bit | g_or[2].ovl_bit |
                           g_or[3].ovl_bit | g_or[4].ovl_bit;
  assign any_ch_openload = g_or[0].ol_bit | g_or[1].ol_bit | g_or[2].ol_bit |
                           g_or[3].ol_bit | g_or[4].ol_bit;
  assign global_overload_flag = any_ch_overload;
  assign global_openload_flag = any_ch_openload;
  // serial_link_fail_flag is reported in its own word but not summed here
  assign global_device_flag   = dev_flags[`DEV_RCF_BIT] | dev_flags[`DEV_UVF_BIT] |
                                dev_flags[`DEV_OVF_BIT] | dev_flags[`DEV_CPF_BIT] |
                                dev_flags[`DEV_PWM_CLOCK_FAULT_BIT] |
                                dev_flags[`DEV_TMF_BIT];
  assign global_flags = {global_device_flag, global_overload_flag,
                         global_openload_flag};
  assign failsafe_indicator = fail_mode_in;

  ////////////////////////////////////////////////////////////////////////////
  // word selection; every word gets its address and the failsafe bit

  always @* begin
    read_word = {`WORD_W{1'b0}};
    case (read_address_select_out)
      `ADDR_INIT1, `ADDR_QUICK: begin
        read_word = {`ADDR_QUICK, failsafe_indicator, global_flags,
                     dev_flags[`DEV_CPF_BIT], dev_flags[`DEV_RCF_BIT],
                     dev_flags[`DEV_PWM_CLOCK_FAULT_BIT], channel_summary_flag};
      end
      `ADDR_CH1, 4'h3, 4'h4, 4'h5, `ADDR_CH5: begin
        read_word = {read_address_select_out, failsafe_indicator, global_flags,
                     1'b0, ch_flags[`CH_FLAG_W*rd_ch_idx +: `CH_FLAG_W]};
      end
      `ADDR_DEVICE: begin
        read_word = {`ADDR_DEVICE, failsafe_indicator, global_flags, 3'h0,
                     dev_flags[`DEV_TMF_BIT], dev_flags[`DEV_OVF_BIT],
                     dev_flags[`DEV_UVF_BIT], dev_flags[`DEV_SERIAL_LINK_FAIL_FLAG_BIT],
                     limp_home_input_state};
      end
      `ADDR_LIVE_PINS: begin
        // comparator bits mean nothing while the supply is low
        read_word = {`ADDR_LIVE_PINS, failsafe_indicator, 1'b0, |toggle_state,
                     control_input_state, output_comparator_state};
      end
      `ADDR_IDENTITY: begin
        read_word = {`ADDR_IDENTITY, failsafe_indicator, 3'h0,
                     dev_flags[`DEV_UVF_BIT] ? `ID_BLANK : PART_CODE};
      end
      default: begin
        // unmapped addresses return only address and failsafe bit
        read_word = {read_address_select_out, failsafe_indicator, 11'h000};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // link edge detection on the synchronised clock

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // frame engine: capture at select, sample on rise, shift on fall;
  // a frame of other than sixteen bits changes no selection

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_ff                 <= ST_IDLE;
      tx_ff                    <= {`WORD_W{1'b0}};
      rx_ff                    <= {`WORD_W{1'b0}};
      bit_cnt_ff               <= {`BIT_CNT_W{1'b0}};
      spi_miso_out             <= 1'b0;
      spi_miso_oe_out          <= 1'b0;
      read_address_select_out  <= `ADDR_QUICK;
      readback_persistence_out <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (!cs_n_s) begin
            tx_ff           <= read_word;
            spi_miso_out    <= read_word[`WORD_W-1];
            spi_miso_oe_out <= 1'b1;
            bit_cnt_ff      <= {`BIT_CNT_W{1'b0}};
            state_ff        <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_n_s) begin
            spi_miso_oe_out <= 1'b0;
            state_ff        <= ST_IDLE;
            if (bit_cnt_ff == `FRAME_BITS) begin
              if (rx_ff[`ADDR_MSB:`ADDR_LSB] == `ADDR_INIT1) begin
                read_address_select_out  <= rx_ff[`SI_RSEL_MSB:`SI_RSEL_LSB];
                readback_persistence_out <= rx_ff[`SI_PERSIST_BIT];
              end else if (!readback_persistence_out) begin
                read_address_select_out  <= `ADDR_QUICK;
              end
              // persistence high keeps the selection as it is
            end
          end else begin
            if (sclk_rise) begin
              rx_ff <= {rx_ff[`WORD_W-2:0], mosi_s};
              if (bit_cnt_ff != {`BIT_CNT_W{1'b1}}) begin
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
              end
            end
            if (sclk_fall) begin
              // msb first; zeros follow once the word is out
              tx_ff        <= {tx_ff[`WORD_W-2:0], 1'b0};
              spi_miso_out <= tx_ff[`WORD_W-2];
            end
          end
        end
        default: begin
          state_ff        <= ST_IDLE;
          spi_miso_oe_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // switch_fault_status_readout

/* File: bench/spi_host_model.sv */
// host side serial master model that drives the status readout link
`timescale 1ns/100ps
module spi_host_model (
  output logic spi_sclk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input  wire  spi_miso_in
);
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // frame of n link clocks, clock idle low, data msb first both ways
  // pins move by non-blocking assignment so edges never race the sampling clock
  task automatic xfer_n(input int n, input logic [15:0] tx, output logic [15:0] rx);
    logic [15:0] sh;
    sh = tx;
    rx = 16'h0000;
    spi_cs_n_out <= 1'b0;
    spi_mosi_out <= sh[15];
    #320;
    repeat (n) begin
      spi_sclk_out <= 1'b1;
      #150;
      rx = {rx[14:0], spi_miso_in};  // late in the high phase, answer lags 3 clocks
      #10;
      spi_sclk_out <= 1'b0;
      sh = {sh[14:0], ~sh[15]};      // after sixteen clocks the released line holds the inverse of bit 15
      spi_mosi_out <= sh[15];
      #160;
    end
    spi_cs_n_out <= 1'b1;
    #480;  // gap well over 4 clocks lets the selection settle
  endtask

  // one full 16 bit frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    xfer_n(16, tx, rx);
  endtask

  // init word: zero address field, persistence in bit 4, read address in 3:0
  task automatic init_write(input logic [3:0] a, input logic p, output logic [15:0] rx);
    xfer({11'h000, p, a}, rx);
  endtask
endmodule // spi_host_model

/* File: bench/switch_fault_status_readout_checker.sv */
// concurrent checks on the status readout ports
`timescale 1ns/100ps
module switch_fault_status_readout_checker (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       spi_sclk_in,
  input wire logic       spi_cs_n_in,
  input wire logic       spi_miso_out,
  input wire logic       spi_miso_oe_out,
  input wire logic [3:0] read_address_select_out,
  input wire logic       readback_persistence_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  // frame edges and a quiet link of six cycles seen at the pins
  sequence cs_drop;
    $fell(spi_cs_n_in);
  endsequence
  sequence cs_lift;
    $rose(spi_cs_n_in);
  endsequence
  sequence link_quiet;
    spi_cs_n_in [*6];
  endsequence

  addr_reset_a: assert property ($fell(sys_rst_in) |->
    read_address_select_out == 4'h1 && !readback_persistence_out)
    else $error("selection not back to quick status after reset");
  oe_open_a: assert property (cs_drop |-> ##[2:5] spi_miso_oe_out)
    else $error("output not enabled after frame start");
  oe_close_a: assert property (cs_lift |-> ##[2:5] !spi_miso_oe_out)
    else $error("output still enabled after frame end");
  oe_idle_a: assert property (link_quiet |-> !spi_miso_oe_out)
    else $error("output enabled outside a frame");
  // first bit out is the top address bit of the selected word
  msb_first_a: assert property ($rose(spi_miso_oe_out) |->
    spi_miso_out == read_address_select_out[3])
    else $error("first bit is not address bit 15");
  // shifting only follows a falling link clock, never a rising one
  miso_shift_a: assert property (spi_miso_oe_out && $past(spi_miso_oe_out)
    && $changed(spi_miso_out) |-> !$past(spi_sclk_in, 2))
    else $error("serial output moved without a falling clock");
  sel_frame_a: assert property ($changed(read_address_select_out) |->
    spi_cs_n_in && !spi_miso_oe_out)
    else $error("read address changed inside a frame");
  persist_frame_a: assert property ($changed(readback_persistence_out) |->
    spi_cs_n_in && !spi_miso_oe_out)
    else $error("persistence changed inside a frame");
endmodule // switch_fault_status_readout_checker

bind switch_fault_status_readout switch_fault_status_readout_checker u_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
  .read_address_select_out(read_address_select_out),
  .readback_persistence_out(readback_persistence_out)
);

/* File: bench/test_switch_fault_status_readout.sv */
// self-checking bench for the serial status readout
`timescale 1ns/100ps
module test_switch_fault_status_readout;
  localparam logic [7:0] PART = 8'h5A;  // arbitrary value
  localparam logic [15:0] RD = 16'hF000; // plain read, never an init word
  logic        clk, rst, sclk, cs_n, mosi, miso, oe, pers, fm, limp;
  logic [3:0]  addr, ins, tog;
  logic [4:0]  ots, otw, oc, olon, oloff, cmp;
  logic [14:0] occl;
  logic [5:0]  dev;
  logic [15:0] cut_rx;
  int          err_total, n_tests;

  switch_fault_status_readout #(.PART_CODE(PART)) u_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
    .read_address_select_out(addr), .readback_persistence_out(pers),
    .fail_mode_in(fm), .ots_evt_in(ots), .otw_evt_in(otw), .oc_evt_in(oc),
    .oc_class_in(occl), .olon_evt_in(olon), .oloff_evt_in(oloff),
    .factory_test_evt_in(dev[5]), .overvoltage_evt_in(dev[4]),
    .undervoltage_evt_in(dev[3]), .serial_fail_evt_in(dev[2]),
    .charge_pump_evt_in(dev[1]), .pwm_clock_evt_in(dev[0]),
    .limp_home_pin_in(limp), .control_input_pin_in(ins), .toggle_pin_in(tog),
    .output_comparator_pin_in(cmp));

  spi_host_model u_host (.spi_sclk_out(sclk), .spi_cs_n_out(cs_n),
    .spi_mosi_out(mosi), .spi_miso_in(miso));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, frame and event helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] exp);
    logic [15:0] r;
    u_host.xfer(RD, r);
    chk(r, exp);
  endtask
  task automatic pg(input logic [3:0] a, input logic p, input logic [15:0] exp);
    logic [15:0] r;
    u_host.init_write(a, p, r);
    chk(r, exp);
  endtask
  // one clock pulse on the event inputs, then idle
  task automatic fire(input logic [4:0] s, w, o, n, f, input logic [14:0] c,
                      input logic [5:0] d);
    @(posedge clk);
    ots <= s; otw <= w; oc <= o; olon <= n; oloff <= f; occl <= c; dev <= d;
    @(posedge clk);
    ots <= 5'h00; otw <= 5'h00; oc <= 5'h00; olon <= 5'h00; oloff <= 5'h00;
    dev <= 6'h00;
  endtask
  task automatic reset3;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hung frame ends the run as a mismatch
  initial begin
    #1ms;
    err_total++;
    results();
  end

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1; fm = 1'b0; limp = 1'b0; ins = 4'h0; tog = 4'h0; cmp = 5'h00;
    ots = 5'h00; otw = 5'h00; oc = 5'h00; olon = 5'h00; oloff = 5'h00;
    occl = 15'h0000; dev = 6'h00; err_total = 0; n_tests = 0;
    reset3();
    chk({12'h000, addr}, 16'h0001);
    rd(16'h1440);
    pg(4'h7, 1'b0, 16'h1440);
    chk({12'h000, addr}, 16'h0007);
    rd(16'h7400);
    rd(16'h1000);
    // two overcurrent events on channel 3, the second one must win
    fire(5'h00, 5'h00, 5'h04, 5'h00, 5'h00, 15'h00C0, 6'h00);
    fire(5'h00, 5'h04, 5'h04, 5'h00, 5'h00, 15'h0140, 6'h00);
    rd(16'h1204);
    pg(4'h4, 1'b1, 16'h1204);
    rd(16'h4234);
    rd(16'h4000);
    fire(5'h02, 5'h00, 5'h00, 5'h10, 5'h01, 15'h0000, 6'h00);
    rd(16'h4300);
    pg(4'h2, 1'b0, 16'h4300);
    rd(16'h2301);
    rd(16'h1312);
    pg(4'h3, 1'b0, 16'h1312);
    rd(16'h3340);
    pg(4'h6, 1'b1, 16'h1110);
    rd(16'h6102);
    pg(4'h0, 1'b0, 16'h6000);
    rd(16'h1000);
    // device faults, fail mode and live pins
    @(posedge clk);
    fm <= 1'b1; limp <= 1'b1; ins <= 4'hA; tog <= 4'h2; cmp <= 5'h15;
    fire(5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 15'h0000, 6'h3F);
    rd(16'h1CA0);
    pg(4'h9, 1'b0, 16'h1CA0);
    rd(16'h9800);
    pg(4'h7, 1'b1, 16'h1CA0);
    rd(16'h7C1F);
    rd(16'h7801);
    pg(4'h8, 1'b0, 16'h7801);
    rd(16'h8B55);
    pg(4'h9, 1'b0, 16'h1800);
    rd({8'h98, PART});
    // unmapped address, then a cut init frame that must change no selection
    pg(4'hA, 1'b0, 16'h1800);
    rd(16'hA800);
    u_host.xfer_n(15, 16'h000B, cut_rx);
    chk(cut_rx, 16'h0C00);
    chk({12'h000, addr}, 16'h0001);
    // factory test flag was seen, so the host resets the device
    reset3();
    chk({11'h000, pers, addr}, 16'h0001);
    rd(16'h1C40);
    results();
  end
endmodule // test_switch_fault_status_readout
